// ===== tb.sv
`timescale 1ns/1ps
`include "utec_defines.svh"
// register-level bench for the task and event controller
module tb;
    // clock, reset, register port
    logic        clk, rst_n, wr, rd;
    logic [11:0] addr, a;
    logic [31:0] wdata, rdata;
    // engine side and endpoint state
    logic        br, sof, iic, ioh, ack, oreq, sreq, ien, oen, dal, sal;
    logic        stall, lf;
    logic [1:0]  lv;
    logic [7:0]  in_c, out_h, cause, in_en, out_en;
    logic [255:0] ip, il, op, ol;
    logic [31:0] iip, iil, iop, iol;
    logic [11:0] ev_a [5] = '{`UTEC_BUS_RESET_EVT, `UTEC_FRAME_START_EVT,
        `UTEC_ISO_IN_END_EVT, `UTEC_ISO_OUT_END_EVT, `UTEC_CTRL_DONE_EVT};
    int bad_count = 0, n_compared = 0, cyc = 0;
    utec_task_event_ctrl utec_task_event_ctrl_i (.i_clk_sys(clk),
        .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_bus_reset(br), .i_frame_start(sof), .i_in_consumed(in_c),
        .i_out_handled(out_h), .i_iso_in_consumed(iic),
        .i_iso_out_handled(ioh), .i_ctrl_data_acked(ack),
        .i_ctrl_out_data_req(oreq), .i_ctrl_status_req(sreq),
        .i_general_cause(cause), .o_in_ep_enable(in_en),
        .o_out_ep_enable(out_en), .o_iso_in_enable(ien),
        .o_iso_out_enable(oen), .o_ctrl_data_allow(dal),
        .o_ctrl_status_allow(sal), .o_ctrl_stall(stall), .o_in_ptr(ip),
        .o_in_lim(il), .o_out_ptr(op), .o_out_lim(ol), .o_iso_in_ptr(iip),
        .o_iso_in_lim(iil), .o_iso_out_ptr(iop), .o_iso_out_lim(iol),
        .o_line_force(lf), .o_line_value(lv));
    utec_engine_model utec_engine_model_i (.i_clk_sys(clk),
        .o_bus_reset(br), .o_frame_start(sof), .o_iso_in_consumed(iic),
        .o_iso_out_handled(ioh), .o_ctrl_data_acked(ack),
        .o_in_consumed(in_c), .o_out_handled(out_h),
        .o_general_cause(cause), .o_ctrl_out_data_req(oreq),
        .o_ctrl_status_req(sreq));
    // free-running clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr32(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one-cycle read strobe, data in the following cycle only
    task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    // verdict
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {rst_n, wr, rd, addr, wdata} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // endpoint start tasks, in then out side
        for (int s = 0; s < 2; s++)
            for (int n = 0; n < 8; n++)
            begin
                a = 12'(`UTEC_EP_STRIDE * n) + (s ? 12'h700 : 12'h600);
                wr32(a, 32'h2000_0000 + 32'(n * 16 + s));
                wr32(a + 12'h004, 32'h40 + 32'(n));
                a = 12'(4 * n) + (s ? 12'h028 : 12'h004);
                wr32(a, 32'h0);
                @(negedge clk);
                chk(s ? out_en[n] : in_en[n], 0);
                wr32(a, 32'h1);
                @(negedge clk);
                chk(s ? out_en[n] : in_en[n], 1);
                chk(s ? op[32*n+:32] : ip[32*n+:32],
                    32'h2000_0000 + 32'(n * 16 + s));
                chk(s ? ol[32*n+:32] : il[32*n+:32], 32'h40 + n);
                @(posedge clk);
                rdchk(`UTEC_CAPTURE_DONE_EVT, 32'h1);
                rdchk(`UTEC_EP_CAPTURE_STATUS, 32'h1 << (n + 16 * s));
                wr32(`UTEC_EP_CAPTURE_STATUS, 32'hffff_ffff);
                wr32(`UTEC_CAPTURE_DONE_EVT, 32'h0);
                rdchk(`UTEC_CAPTURE_DONE_EVT, 32'h0);
            end
        // isochronous start tasks
        wr32(`UTEC_ISO_IN_PTR, 32'h3000_0004);
        wr32(`UTEC_ISO_IN_LIM, 32'h3ff);
        wr32(`UTEC_ISO_OUT_PTR, 32'h3100_0008);
        wr32(`UTEC_ISO_OUT_LIM, 32'h200);
        wr32(`UTEC_ISO_IN_START, 32'h1);
        wr32(`UTEC_ISO_OUT_START, 32'h1);
        @(negedge clk);
        chk(ien, 1);
        chk(iip, 32'h3000_0004);
        chk(iil, 32'h3ff);
        chk(oen, 1);
        chk(iop, 32'h3100_0008);
        chk(iol, 32'h200);
        $display("start task test done");
        // every dedicated event but capture done: clear, pulse, sticky, clear by 0
        for (int k = 0; k < 21; k++)
        begin
            a = k < 5 ? ev_a[k] : k < 13 ? 12'h108 + 12'(4 * (k - 5))
                : 12'h130 + 12'(4 * (k - 13));
            rdchk(a, 32'h0);
            utec_engine_model_i.pulse(29'h1 << k);
            rdchk(a, 32'h1);
            rdchk(a, 32'h1);
            wr32(a, 32'h0);
            rdchk(a, 32'h0);
        end
        // general event and its cause bits
        for (int k = 0; k < 8; k++)
        begin
            rdchk(`UTEC_GENERAL_EVT, 32'h0);
            utec_engine_model_i.pulse(29'h1 << (21 + k));
            rdchk(`UTEC_GENERAL_EVT, 32'h1);
            rdchk(`UTEC_GENERAL_CAUSE, 32'h1 << k);
            wr32(`UTEC_GENERAL_CAUSE, 32'h1 << k);
            wr32(`UTEC_GENERAL_EVT, 32'h0);
            rdchk(`UTEC_GENERAL_CAUSE, 32'h0);
        end
        $display("event test done");
        // ep0 stages held back until software allows them
        utec_engine_model_i.request(1'b1, 1'b0);
        repeat (2) @(negedge clk);
        chk(dal, 0);
        wr32(`UTEC_CTRL_RECEIVE, 32'h1);
        @(negedge clk);
        chk(dal, 1);
        utec_engine_model_i.request(1'b0, 1'b1);
        repeat (2) @(negedge clk);
        chk(sal, 0);
        wr32(`UTEC_CTRL_STATUS, 32'h1);
        @(negedge clk);
        chk(sal, 1);
        utec_engine_model_i.request(1'b0, 1'b0);
        wr32(`UTEC_CTRL_STALL, 32'h1);
        @(negedge clk);
        chk(stall, 1);
        utec_engine_model_i.pulse(29'h1);
        @(negedge clk);
        chk(stall, 0);
        // line forcing and release, unmapped place
        wr32(`UTEC_LINE_STATE_VALUE, 32'h2);
        @(negedge clk);
        chk(lf, 0);
        wr32(`UTEC_LINE_FORCE, 32'h1);
        @(negedge clk);
        chk({lf, lv}, 3'b110);
        wr32(`UTEC_LINE_RELEASE, 32'h1);
        @(negedge clk);
        chk(lf, 0);
        wr32(12'h7fc, 32'h5);
        rdchk(12'h7fc, 32'h0);
        $display("control and line test done");
        summarize();
    end
endmodule

// ===== utec_defines.svh
`ifndef UTEC_DEFINES_SVH
`define UTEC_DEFINES_SVH
// task offsets
`define UTEC_IN_EP_START_BASE   12'h004
`define UTEC_ISO_IN_START       12'h024
`define UTEC_OUT_EP_START_BASE  12'h028
`define UTEC_ISO_OUT_START      12'h048
`define UTEC_CTRL_RECEIVE       12'h04c
`define UTEC_CTRL_STATUS        12'h050
`define UTEC_CTRL_STALL         12'h054
`define UTEC_LINE_FORCE         12'h058
`define UTEC_LINE_RELEASE       12'h05c
// event offsets
`define UTEC_BUS_RESET_EVT      12'h100
`define UTEC_CAPTURE_DONE_EVT   12'h104
`define UTEC_IN_END_EVT_BASE    12'h108
`define UTEC_CTRL_DONE_EVT      12'h128
`define UTEC_ISO_IN_END_EVT     12'h12c
`define UTEC_OUT_END_EVT_BASE   12'h130
`define UTEC_ISO_OUT_END_EVT    12'h150
`define UTEC_FRAME_START_EVT    12'h154
`define UTEC_GENERAL_EVT        12'h158
// status and configuration
`define UTEC_GENERAL_CAUSE      12'h400
`define UTEC_EP_CAPTURE_STATUS  12'h468
`define UTEC_LINE_STATE_VALUE   12'h508
`define UTEC_IN_PTR_BASE        12'h600
`define UTEC_IN_LIM_BASE        12'h604
`define UTEC_ISO_IN_PTR         12'h6a0
`define UTEC_ISO_IN_LIM         12'h6a4
`define UTEC_OUT_PTR_BASE       12'h700
`define UTEC_OUT_LIM_BASE       12'h704
`define UTEC_ISO_OUT_PTR        12'h7a0
`define UTEC_ISO_OUT_LIM        12'h7a4
// strides
`define UTEC_TASK_STRIDE        12'h004
`define UTEC_EP_STRIDE          12'h014
// reset value of every register
`define UTEC_RESET_VALUE        32'h0000_0000
`endif

// ===== utec_engine_model.sv
`timescale 1ns/1ps
// behavioural protocol engine: one-cycle event pulses, stage request levels
module utec_engine_model (
    // clock
    input  wire logic       i_clk_sys,
    // event pulses
    output logic            o_bus_reset,
    output logic            o_frame_start,
    output logic            o_iso_in_consumed,
    output logic            o_iso_out_handled,
    output logic            o_ctrl_data_acked,
    output logic [7:0]      o_in_consumed,
    output logic [7:0]      o_out_handled,
    output logic [7:0]      o_general_cause,
    // pending ep0 stage requests
    output logic            o_ctrl_out_data_req,
    output logic            o_ctrl_status_req
);
    logic [28:0] ev_ff = '0;  // packed pulses, quiet between events
    assign {o_general_cause, o_out_handled, o_in_consumed} = ev_ff[28:5];
    assign {o_ctrl_data_acked, o_iso_out_handled} = ev_ff[4:3];
    assign {o_iso_in_consumed, o_frame_start, o_bus_reset} = ev_ff[2:0];
    initial {o_ctrl_out_data_req, o_ctrl_status_req} = 2'b00;
    // pulse the chosen bits for exactly one cycle
    task automatic pulse(input logic [28:0] m);
        @(posedge i_clk_sys);
        ev_ff <= m;
        @(posedge i_clk_sys);
        ev_ff <= '0;
    endtask
    // raise or drop the host's pending stage attempts
    task automatic request(input logic o_req, input logic s_req);
        @(posedge i_clk_sys);
        o_ctrl_out_data_req <= o_req;
        o_ctrl_status_req   <= s_req;
    endtask
endmodule

// ===== utec_pkg.sv
package utec_pkg;
    // endpoint 0 control stage state
    typedef enum logic [1:0] {
        UTEC_CTRL_IDLE,
        UTEC_CTRL_WAIT_DATA,
        UTEC_CTRL_WAIT_STATUS,
        UTEC_CTRL_STALLED
    } utec_ctrl_t;
endpackage

// ===== utec_task_event_ctrl.sv
`timescale 1ns/1ps
`include "utec_defines.svh"
module utec_task_event_ctrl #(
    parameter int NUM_EP   = 8,
    parameter int CAUSE_W  = 8
) (
    // clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_n,
    // register port
    input  wire logic [11:0]        i_reg_addr,
    input  wire logic [31:0]        i_reg_wdata,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    output logic      [31:0]        o_reg_rdata,
    // protocol engine events
    input  wire logic               i_bus_reset,
    input  wire logic               i_frame_start,
    input  wire logic [NUM_EP-1:0]  i_in_consumed,
    input  wire logic [NUM_EP-1:0]  i_out_handled,
    input  wire logic               i_iso_in_consumed,
    input  wire logic               i_iso_out_handled,
    input  wire logic               i_ctrl_data_acked,
    input  wire logic               i_ctrl_out_data_req,
    input  wire logic               i_ctrl_status_req,
    input  wire logic [CAUSE_W-1:0] i_general_cause,
    // endpoint state to engine
    output logic      [NUM_EP-1:0]  o_in_ep_enable,
    output logic      [NUM_EP-1:0]  o_out_ep_enable,
    output logic                    o_iso_in_enable,
    output logic                    o_iso_out_enable,
    output logic                    o_ctrl_data_allow,
    output logic                    o_ctrl_status_allow,
    output logic                    o_ctrl_stall,
    // captured buffer descriptors, flattened per endpoint
    output logic [NUM_EP*32-1:0]    o_in_ptr,
    output logic [NUM_EP*32-1:0]    o_in_lim,
    output logic [NUM_EP*32-1:0]    o_out_ptr,
    output logic [NUM_EP*32-1:0]    o_out_lim,
    output logic [31:0]             o_iso_in_ptr,
    output logic [31:0]             o_iso_in_lim,
    output logic [31:0]             o_iso_out_ptr,
    output logic [31:0]             o_iso_out_lim,
    // line forcing
    output logic                    o_line_force,
    output logic [1:0]              o_line_value
);

    // whole module state
    typedef struct packed {
        logic [NUM_EP-1:0][31:0] in_ptr_sw;   // software pointer regs
        logic [NUM_EP-1:0][31:0] in_lim_sw;
        logic [NUM_EP-1:0][31:0] out_ptr_sw;
        logic [NUM_EP-1:0][31:0] out_lim_sw;
        logic [3:0][31:0]        iso_sw;      // iso in ptr/lim, out ptr/lim
        logic [NUM_EP-1:0][31:0] in_ptr_cap;  // captured copies
        logic [NUM_EP-1:0][31:0] in_lim_cap;
        logic [NUM_EP-1:0][31:0] out_ptr_cap;
        logic [NUM_EP-1:0][31:0] out_lim_cap;
        logic [3:0][31:0]        iso_cap;
        logic [NUM_EP-1:0]       in_en;
        logic [NUM_EP-1:0]       out_en;
        logic                    iso_in_en;
        logic                    iso_out_en;
        logic [31:0]             cap_status;  // in low half, out high half
        logic                    capture_pend;
        utec_pkg::utec_ctrl_t    ctrl;
        logic                    bus_reset_f;
        logic                    capture_done_f;
        logic [NUM_EP-1:0]       in_end_f;
        logic [NUM_EP-1:0]       out_end_f;
        logic                    ctrl_done_f;
        logic                    iso_in_end_f;
        logic                    iso_out_end_f;
        logic                    frame_f;
        logic                    general_f;
        logic [CAUSE_W-1:0]      cause;
        logic                    force_on;
        logic [1:0]              line_val;
        logic [31:0]             rdata;
    } utec_state_t;

    utec_state_t st_ff;      // registered state
    utec_state_t nxt_st;     // next state

    // endpoint index for a strided address, or -1
    function automatic int ep_idx(input logic [11:0] a,
                                  input logic [11:0] base,
                                  input logic [11:0] stride);
        int k;
        ep_idx = -1;
        for (k = 0; k < NUM_EP; k++)
            if (a == 12'(base + 12'(k) * stride))
                ep_idx = k;
    endfunction

    // sticky flag: set wins over software clear
    function automatic logic evt(input logic cur, input logic set,
                                 input logic clr);
        evt = set | (cur & ~clr);
    endfunction

    int          ti_in;     // in start task hit
    int          ti_out;    // out start task hit
    int          ei_in;     // in end event hit
    int          ei_out;    // out end event hit
    int          ri_ip;     // per-endpoint descriptor hits
    int          ri_il;
    int          ri_op;
    int          ri_ol;
    logic        trig;      // write with bit0 set
    logic        clr;       // write with bit0 clear

    // next-state logic
    always_comb
    begin
        nxt_st = st_ff;
        trig   = i_reg_wr & i_reg_wdata[0];
        clr    = i_reg_wr & ~i_reg_wdata[0];
        ti_in  = ep_idx(i_reg_addr, `UTEC_IN_EP_START_BASE,
                        `UTEC_TASK_STRIDE);
        ti_out = ep_idx(i_reg_addr, `UTEC_OUT_EP_START_BASE,
                        `UTEC_TASK_STRIDE);
        ei_in  = ep_idx(i_reg_addr, `UTEC_IN_END_EVT_BASE,
                        `UTEC_TASK_STRIDE);
        ei_out = ep_idx(i_reg_addr, `UTEC_OUT_END_EVT_BASE,
                        `UTEC_TASK_STRIDE);
        ri_ip  = ep_idx(i_reg_addr, `UTEC_IN_PTR_BASE, `UTEC_EP_STRIDE);
        ri_il  = ep_idx(i_reg_addr, `UTEC_IN_LIM_BASE, `UTEC_EP_STRIDE);
        ri_op  = ep_idx(i_reg_addr, `UTEC_OUT_PTR_BASE, `UTEC_EP_STRIDE);
        ri_ol  = ep_idx(i_reg_addr, `UTEC_OUT_LIM_BASE, `UTEC_EP_STRIDE);
        nxt_st.capture_pend = 1'b0;
        // capture done one cycle after an in or out endpoint capture
        if (st_ff.capture_pend)
            nxt_st.capture_done_f = 1'b1;
        // descriptor, line value and capture status writes
        if (i_reg_wr)
        begin
            if (ri_ip >= 0)
                nxt_st.in_ptr_sw[ri_ip] = i_reg_wdata;
            else if (ri_il >= 0)
                nxt_st.in_lim_sw[ri_il] = i_reg_wdata;
            else if (ri_op >= 0)
                nxt_st.out_ptr_sw[ri_op] = i_reg_wdata;
            else if (ri_ol >= 0)
                nxt_st.out_lim_sw[ri_ol] = i_reg_wdata;
            else if (i_reg_addr == `UTEC_ISO_IN_PTR)
                nxt_st.iso_sw[0] = i_reg_wdata;
            else if (i_reg_addr == `UTEC_ISO_IN_LIM)
                nxt_st.iso_sw[1] = i_reg_wdata;
            else if (i_reg_addr == `UTEC_ISO_OUT_PTR)
                nxt_st.iso_sw[2] = i_reg_wdata;
            else if (i_reg_addr == `UTEC_ISO_OUT_LIM)
                nxt_st.iso_sw[3] = i_reg_wdata;
            else if (i_reg_addr == `UTEC_LINE_STATE_VALUE)
                nxt_st.line_val = i_reg_wdata[1:0];
            else if (i_reg_addr == `UTEC_EP_CAPTURE_STATUS)
                nxt_st.cap_status = st_ff.cap_status & ~i_reg_wdata;
        end
        // start tasks
        if (trig)
        begin
            if (ti_in >= 0)
            begin
                nxt_st.in_ptr_cap[ti_in] = st_ff.in_ptr_sw[ti_in];
                nxt_st.in_lim_cap[ti_in] = st_ff.in_lim_sw[ti_in];
                nxt_st.in_en[ti_in]      = 1'b1;
                nxt_st.cap_status[ti_in] = 1'b1;
                nxt_st.capture_pend      = 1'b1;
            end
            else if (ti_out >= 0)
            begin
                nxt_st.out_ptr_cap[ti_out] = st_ff.out_ptr_sw[ti_out];
                nxt_st.out_lim_cap[ti_out] = st_ff.out_lim_sw[ti_out];
                nxt_st.out_en[ti_out]      = 1'b1;
                nxt_st.cap_status[16 + ti_out] = 1'b1;
                nxt_st.capture_pend        = 1'b1;
            end
            else if (i_reg_addr == `UTEC_ISO_IN_START)
            begin
                nxt_st.iso_cap[1:0] = st_ff.iso_sw[1:0];
                nxt_st.iso_in_en    = 1'b1;
            end
            else if (i_reg_addr == `UTEC_ISO_OUT_START)
            begin
                nxt_st.iso_cap[3:2] = st_ff.iso_sw[3:2];
                nxt_st.iso_out_en   = 1'b1;
            end
            else if (i_reg_addr == `UTEC_LINE_FORCE)
                nxt_st.force_on = 1'b1;
            else if (i_reg_addr == `UTEC_LINE_RELEASE)
                nxt_st.force_on = 1'b0;
        end
        // endpoint 0 stages: host attempts alone never open a stage
        case (st_ff.ctrl)
            utec_pkg::UTEC_CTRL_WAIT_DATA:
                if (i_ctrl_data_acked)
                    nxt_st.ctrl = utec_pkg::UTEC_CTRL_IDLE;
            utec_pkg::UTEC_CTRL_WAIT_STATUS:
                if (!i_ctrl_status_req)
                    nxt_st.ctrl = utec_pkg::UTEC_CTRL_IDLE;
            default:
                nxt_st.ctrl = st_ff.ctrl;          // idle and stall hold
        endcase
        // control tasks override engine requests
        if (trig && i_reg_addr == `UTEC_CTRL_RECEIVE)
            nxt_st.ctrl = utec_pkg::UTEC_CTRL_WAIT_DATA;
        else if (trig && i_reg_addr == `UTEC_CTRL_STATUS)
            nxt_st.ctrl = utec_pkg::UTEC_CTRL_WAIT_STATUS;
        if (trig && i_reg_addr == `UTEC_CTRL_STALL)
            nxt_st.ctrl = utec_pkg::UTEC_CTRL_STALLED;
        // a bus reset clears the stall
        if (i_bus_reset)
            nxt_st.ctrl = utec_pkg::UTEC_CTRL_IDLE;
        // sticky event flags
        nxt_st.bus_reset_f = evt(st_ff.bus_reset_f, i_bus_reset,
            clr && i_reg_addr == `UTEC_BUS_RESET_EVT);
        nxt_st.capture_done_f = evt(nxt_st.capture_done_f, 1'b0,
            clr && i_reg_addr == `UTEC_CAPTURE_DONE_EVT && !st_ff.capture_pend);
        nxt_st.ctrl_done_f = evt(st_ff.ctrl_done_f, i_ctrl_data_acked,
            clr && i_reg_addr == `UTEC_CTRL_DONE_EVT);
        nxt_st.iso_in_end_f = evt(st_ff.iso_in_end_f, i_iso_in_consumed,
            clr && i_reg_addr == `UTEC_ISO_IN_END_EVT);
        nxt_st.iso_out_end_f = evt(st_ff.iso_out_end_f, i_iso_out_handled,
            clr && i_reg_addr == `UTEC_ISO_OUT_END_EVT);
        nxt_st.frame_f = evt(st_ff.frame_f, i_frame_start,
            clr && i_reg_addr == `UTEC_FRAME_START_EVT);
        nxt_st.general_f = evt(st_ff.general_f, |i_general_cause,
            clr && i_reg_addr == `UTEC_GENERAL_EVT);
        for (int k = 0; k < NUM_EP; k++)
        begin
            nxt_st.in_end_f[k] = evt(st_ff.in_end_f[k], i_in_consumed[k],
                clr && ei_in == k);
            nxt_st.out_end_f[k] = evt(st_ff.out_end_f[k], i_out_handled[k],
                clr && ei_out == k);
        end
        // cause bits: write one to clear, new cause wins
        if (i_reg_wr && i_reg_addr == `UTEC_GENERAL_CAUSE)
            nxt_st.cause = st_ff.cause & ~i_reg_wdata[CAUSE_W-1:0];
        nxt_st.cause = nxt_st.cause | i_general_cause;
        // read data, valid the cycle after the strobe
        nxt_st.rdata = `UTEC_RESET_VALUE;
        if (i_reg_rd)
        begin
            if (ei_in >= 0)
                nxt_st.rdata[0] = st_ff.in_end_f[ei_in];
            else if (ei_out >= 0)
                nxt_st.rdata[0] = st_ff.out_end_f[ei_out];
            else if (ri_ip >= 0)
                nxt_st.rdata = st_ff.in_ptr_sw[ri_ip];
            else if (ri_il >= 0)
                nxt_st.rdata = st_ff.in_lim_sw[ri_il];
            else if (ri_op >= 0)
                nxt_st.rdata = st_ff.out_ptr_sw[ri_op];
            else if (ri_ol >= 0)
                nxt_st.rdata = st_ff.out_lim_sw[ri_ol];
            else if (i_reg_addr == `UTEC_ISO_IN_PTR)
                nxt_st.rdata = st_ff.iso_sw[0];
            else if (i_reg_addr == `UTEC_ISO_IN_LIM)
                nxt_st.rdata = st_ff.iso_sw[1];
            else if (i_reg_addr == `UTEC_ISO_OUT_PTR)
                nxt_st.rdata = st_ff.iso_sw[2];
            else if (i_reg_addr == `UTEC_ISO_OUT_LIM)
                nxt_st.rdata = st_ff.iso_sw[3];
            else if (i_reg_addr == `UTEC_BUS_RESET_EVT)
                nxt_st.rdata[0] = st_ff.bus_reset_f;
            else if (i_reg_addr == `UTEC_CAPTURE_DONE_EVT)
                nxt_st.rdata[0] = st_ff.capture_done_f;
            else if (i_reg_addr == `UTEC_CTRL_DONE_EVT)
                nxt_st.rdata[0] = st_ff.ctrl_done_f;
            else if (i_reg_addr == `UTEC_ISO_IN_END_EVT)
                nxt_st.rdata[0] = st_ff.iso_in_end_f;
            else if (i_reg_addr == `UTEC_ISO_OUT_END_EVT)
                nxt_st.rdata[0] = st_ff.iso_out_end_f;
            else if (i_reg_addr == `UTEC_FRAME_START_EVT)
                nxt_st.rdata[0] = st_ff.frame_f;
            else if (i_reg_addr == `UTEC_GENERAL_EVT)
                nxt_st.rdata[0] = st_ff.general_f;
            else if (i_reg_addr == `UTEC_GENERAL_CAUSE)
                nxt_st.rdata[CAUSE_W-1:0] = st_ff.cause;
            else if (i_reg_addr == `UTEC_EP_CAPTURE_STATUS)
                nxt_st.rdata = st_ff.cap_status;
            else if (i_reg_addr == `UTEC_LINE_STATE_VALUE)
                nxt_st.rdata[1:0] = st_ff.line_val;
        end
    end

    // state register
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // outputs
    assign o_reg_rdata         = st_ff.rdata;
    assign o_in_ep_enable      = st_ff.in_en;
    assign o_out_ep_enable     = st_ff.out_en;
    assign o_iso_in_enable     = st_ff.iso_in_en;
    assign o_iso_out_enable    = st_ff.iso_out_en;
    assign o_ctrl_data_allow   = st_ff.ctrl == utec_pkg::UTEC_CTRL_WAIT_DATA;
    assign o_ctrl_status_allow =
        st_ff.ctrl == utec_pkg::UTEC_CTRL_WAIT_STATUS;
    assign o_ctrl_stall        = st_ff.ctrl == utec_pkg::UTEC_CTRL_STALLED;
    assign o_in_ptr            = st_ff.in_ptr_cap;
    assign o_in_lim            = st_ff.in_lim_cap;
    assign o_out_ptr           = st_ff.out_ptr_cap;
    assign o_out_lim           = st_ff.out_lim_cap;
    assign o_iso_in_ptr        = st_ff.iso_cap[0];
    assign o_iso_in_lim        = st_ff.iso_cap[1];
    assign o_iso_out_ptr       = st_ff.iso_cap[2];
    assign o_iso_out_lim       = st_ff.iso_cap[3];
    assign o_line_force        = st_ff.force_on;
    assign o_line_value        = st_ff.line_val;

    // checks
    property p_in_start;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_wdata[0] && i_reg_addr == `UTEC_IN_EP_START_BASE)
        |=> o_in_ep_enable[0] && o_in_ptr[31:0] == $past(st_ff.in_ptr_sw[0]);
    endproperty
    a_in_start: assert property (p_in_start)
        else $error("in start did not capture");
    property p_iso_in;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_wdata[0] && i_reg_addr == `UTEC_ISO_IN_START)
        |=> o_iso_in_enable;
    endproperty
    a_iso_in: assert property (p_iso_in)
        else $error("iso in not enabled");
    property p_capture;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_wdata[0] && i_reg_addr == `UTEC_OUT_EP_START_BASE)
        |=> ##1 st_ff.capture_done_f;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture done missing");
    property p_stall;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_wdata[0] && i_reg_addr == `UTEC_CTRL_STALL
         && !i_bus_reset) |=> o_ctrl_stall && !o_ctrl_status_allow;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall not applied");
    property p_force;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_reg_wr && i_reg_wdata[0] && i_reg_addr == `UTEC_LINE_RELEASE)
        |=> !o_line_force;
    endproperty
    a_force: assert property (p_force)
        else $error("lines still forced");
    property p_sof;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_frame_start |=> st_ff.frame_f;
    endproperty
    a_sof: assert property (p_sof)
        else $error("frame flag lost");
    property p_reset_evt;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_bus_reset |=> st_ff.bus_reset_f && !o_ctrl_stall;
    endproperty
    a_reset_evt: assert property (p_reset_evt)
        else $error("bus reset flag lost");
    property p_sticky;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (st_ff.general_f && !i_reg_wr) |=> st_ff.general_f;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("general flag dropped");
    c_in_start: cover property (@(posedge i_clk_sys) o_in_ep_enable[0]);
    c_held: cover property (@(posedge i_clk_sys)
        i_ctrl_out_data_req && !o_ctrl_data_allow);
    c_stall: cover property (@(posedge i_clk_sys) o_ctrl_stall);
    c_force: cover property (@(posedge i_clk_sys) o_line_force);
endmodule
